// [src/mcd_consts.vh]
// Constants for the mode code command decoder: register offsets,
// field positions, reset values and decoded function codes.
// Assumes inclusion by bare name from the decoder source files.
`ifndef MCD_CONSTS_VH
`define MCD_CONSTS_VH

// Register byte offsets (low address byte)
`define MCD_OFF_CTRL 8'h00
`define MCD_OFF_ILL_TX 8'h04
`define MCD_OFF_ILL_RX 8'h08
`define MCD_OFF_STATUS 8'h0C
`define MCD_OFF_DATA_BASE 8'h80

// Control register fields
`define MCD_CTRL_UCI_BIT 0
`define MCD_CTRL_SMS_BIT 1
`define MCD_CTRL_RST 2'h0
`define MCD_ILL_RST 32'h00000000

// Status register fields
`define MCD_ST_CODE_LSB 0
`define MCD_ST_TR_BIT 5
`define MCD_ST_BCAST_BIT 6
`define MCD_ST_FUNC_LSB 7
`define MCD_ST_MERR_BIT 11
`define MCD_ST_PEND_BIT 12
`define MCD_ST_UNDEF_BIT 13
`define MCD_ST_RSVD_BIT 14
`define MCD_ST_IGN_BIT 15

// Mode data word reset value
`define MCD_DATA_RST 16'h0000

// Decoded function codes
`define MCD_FN_BUS_CTRL 4'h0
`define MCD_FN_SYNC 4'h1
`define MCD_FN_SEND_STATUS 4'h2
`define MCD_FN_SELF_TEST 4'h3
`define MCD_FN_TX_SHUTDOWN 4'h4
`define MCD_FN_OVR_SHUTDOWN 4'h5
`define MCD_FN_INHIBIT_FLAG 4'h6
`define MCD_FN_OVR_INHIBIT 4'h7
`define MCD_FN_TERM_RESET 4'h8
`define MCD_FN_SEND_VECTOR 4'h9
`define MCD_FN_SYNC_DATA 4'hA
`define MCD_FN_SEND_LAST 4'hB
`define MCD_FN_SEND_BIT 4'hC
`define MCD_FN_SEL_SHUTDOWN 4'hD
`define MCD_FN_OVR_SEL_SHUTDOWN 4'hE
`define MCD_FN_OTHER 4'hF

`endif

// [src/mcd_code_classifier.v]
// Combinational classifier for one mode command: data word presence,
// undefined and reserved classes, broadcast permission, function.
// Assumes code and direction are stable inputs from the same clock.
`timescale 1ns/1ps
`include "mcd_consts.vh"

module mcd_code_classifier (
  // Command fields
  input wire [4:0] code_in,
  input wire tr_in,
  // Classification
  output reg has_data_out,
  output reg undefined_out,
  output reg reserved_out,
  output reg bcast_ok_out,
  output reg [3:0] func_out
);

  always @*
  begin
    has_data_out = code_in[4];
    if (!tr_in)
    begin
      undefined_out = (code_in <= 5'h13) && (code_in != 5'h11);
    end
    else
    begin
      undefined_out = (code_in == 5'h11) || (code_in == 5'h14) || (code_in == 5'h15);
    end
    reserved_out = (tr_in && (code_in >= 5'h09) && (code_in <= 5'h0F)) ||
                   (code_in >= 5'h16);
    if (tr_in)
    begin
      bcast_ok_out = (code_in == 5'h01) || ((code_in >= 5'h03) && (code_in <= 5'h0F));
    end
    else
    begin
      bcast_ok_out = (code_in == 5'h11) || (code_in == 5'h14) || (code_in >= 5'h15);
    end
    func_out = `MCD_FN_OTHER;
    case ({tr_in, code_in})
      6'h20: func_out = `MCD_FN_BUS_CTRL;
      6'h21: func_out = `MCD_FN_SYNC;
      6'h22: func_out = `MCD_FN_SEND_STATUS;
      6'h23: func_out = `MCD_FN_SELF_TEST;
      6'h24: func_out = `MCD_FN_TX_SHUTDOWN;
      6'h25: func_out = `MCD_FN_OVR_SHUTDOWN;
      6'h26: func_out = `MCD_FN_INHIBIT_FLAG;
      6'h27: func_out = `MCD_FN_OVR_INHIBIT;
      6'h28: func_out = `MCD_FN_TERM_RESET;
      6'h30: func_out = `MCD_FN_SEND_VECTOR;
      6'h32: func_out = `MCD_FN_SEND_LAST;
      6'h33: func_out = `MCD_FN_SEND_BIT;
      6'h11: func_out = `MCD_FN_SYNC_DATA;
      6'h14: func_out = `MCD_FN_SEL_SHUTDOWN;
      6'h15: func_out = `MCD_FN_OVR_SEL_SHUTDOWN;
      default: func_out = `MCD_FN_OTHER;
    endcase
  end

endmodule // mcd_code_classifier

// [src/mcd_mode_decoder.v]
// Mode code command decoder of a serial command/response remote
// terminal, with an AHB-Lite register slave and in-block mode data.
// Assumes the protocol engine on the same clock presents each decoded
// mode command as a one-cycle strobe and reports message completion.
//
// Behaviour
// - Codes 0-15 carry no data word.
// - Valid non-broadcast 0-15: status word only.
// - Codes 16-31 carry one data word.
// - Legal transmit 16-31: status plus one word.
// - Normal storage: data to descriptor buffer.
// - Simplified storage: data kept in descriptor entry.
// - No circular buffering for mode commands.
// - Direction one broadcast: codes 1, 3-15.
// - Direction zero broadcast: 17, 20, 21, 22-31.
// - Decode functions for direction one, codes 0-8.
// - Decode data-word functions 16-21 by direction.
// - Undefined-invalid option: ignore undefined commands fully.
// - Legal undefined commands answer in form.
// - Illegal command: message error, status only unless broadcast.
// - Illegal 16-31: no data sent or stored.
// - Reserved commands follow legality table only.
// - Bus control handover is never accepted.
// - Undefined-invalid option clear after reset.
// - Bus control acceptance status never set.
`timescale 1ns/1ps
`include "mcd_consts.vh"

module mcd_mode_decoder #(
  parameter DATA_W = 16,
  parameter NUM_WORDS = 32
) (
  // Clock and reset
  input wire clk_in,
  input wire rst_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire [31:0] hrdata_out,
  output wire hreadyout_out,
  output wire hresp_out,
  // Mode command from the protocol engine
  input wire cmd_valid_in,
  input wire [4:0] cmd_code_in,
  input wire cmd_tr_in,
  input wire cmd_bcast_in,
  // Message completion and received data word
  input wire msg_done_in,
  input wire msg_err_in,
  input wire [DATA_W-1:0] rx_word_in,
  // Response decision
  output wire resp_valid_out,
  output wire resp_ignore_out,
  output wire resp_status_out,
  output wire resp_tx_data_out,
  output wire resp_rx_data_out,
  output wire [3:0] resp_func_out,
  output wire [DATA_W-1:0] tx_word_out,
  output wire tx_from_buf_out,
  output wire message_error_flag_out,
  output wire bus_ctrl_accept_out,
  // Buffer storage request for normal storage
  output wire store_we_out,
  output wire [5:0] store_sel_out,
  output wire [DATA_W-1:0] store_data_out
);

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // Classifier view of the incoming command
  wire cls_has_data;
  wire cls_undef;
  wire cls_rsvd;
  wire cls_bcast_ok;
  wire [3:0] cls_func;

  mcd_code_classifier u_cls (
    .code_in(cmd_code_in),
    .tr_in(cmd_tr_in),
    .has_data_out(cls_has_data),
    .undefined_out(cls_undef),
    .reserved_out(cls_rsvd),
    .bcast_ok_out(cls_bcast_ok),
    .func_out(cls_func)
  );

  // Software registers
  reg [1:0] ctrl_ff;
  reg [31:0] ill_tx_ff;
  reg [31:0] ill_rx_ff;
  reg [DATA_W-1:0] mdata_ff [0:NUM_WORDS-1];

  // Bus data phase state
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [31:0] hrdata_ff;

  // Response and decode state
  reg state_ff;
  reg resp_valid_ff;
  reg resp_ignore_ff;
  reg resp_status_ff;
  reg resp_tx_data_ff;
  reg resp_rx_data_ff;
  reg [3:0] func_ff;
  reg [DATA_W-1:0] tx_word_ff;
  reg tx_from_buf_ff;
  reg merr_ff;
  reg [4:0] last_code_ff;
  reg last_tr_ff;
  reg last_bcast_ff;
  reg last_undef_ff;
  reg last_rsvd_ff;
  reg [4:0] pend_idx_ff;
  reg store_we_ff;
  reg [5:0] store_sel_ff;
  reg [DATA_W-1:0] store_data_ff;

  wire uci = ctrl_ff[`MCD_CTRL_UCI_BIT];
  wire sms = ctrl_ff[`MCD_CTRL_SMS_BIT];
  wire [4:0] cmd_idx = {cmd_tr_in, cmd_code_in[3:0]};

  wire cmd_ign = cls_undef & uci;
  wire ill_bit = cmd_tr_in ? ill_tx_ff[cmd_code_in] : ill_rx_ff[cmd_code_in];
  // reserved codes judged by table alone
  wire cmd_illegal = ill_bit | (cmd_bcast_in & ~cls_bcast_ok);
  wire cmd_ok = ~cmd_ign & ~cmd_illegal;
  // illegal commands move no data word
  wire rx_expect = cmd_ok & cls_has_data & ~cmd_tr_in;

  // Bus access decode in the address phase
  wire bus_acc = hsel_in & htrans_in[1] & hready_in;
  wire [7:0] a_off = haddr_in[7:0];
  wire a_is_data = (a_off >= `MCD_OFF_DATA_BASE);
  wire [4:0] a_idx = a_off[6:2];
  wire w_is_data = (wr_addr_ff >= `MCD_OFF_DATA_BASE);
  wire [4:0] w_idx = wr_addr_ff[6:2];
  wire hw_store = (state_ff == ST_WAIT) && msg_done_in && !msg_err_in && sms;

  reg [31:0] nxt_hrdata;

  always @*
  begin
    // Unmapped offsets read as zero
    nxt_hrdata = 32'h00000000;
    if (a_is_data)
      nxt_hrdata[DATA_W-1:0] = mdata_ff[a_idx];
    else if (a_off == `MCD_OFF_CTRL)
      nxt_hrdata[1:0] = ctrl_ff;
    else if (a_off == `MCD_OFF_ILL_TX)
      nxt_hrdata = ill_tx_ff;
    else if (a_off == `MCD_OFF_ILL_RX)
      nxt_hrdata = ill_rx_ff;
    else if (a_off == `MCD_OFF_STATUS)
    begin
      nxt_hrdata[`MCD_ST_CODE_LSB+4:`MCD_ST_CODE_LSB] = last_code_ff;
      nxt_hrdata[`MCD_ST_TR_BIT] = last_tr_ff;
      nxt_hrdata[`MCD_ST_BCAST_BIT] = last_bcast_ff;
      nxt_hrdata[`MCD_ST_FUNC_LSB+3:`MCD_ST_FUNC_LSB] = func_ff;
      nxt_hrdata[`MCD_ST_MERR_BIT] = merr_ff;
      nxt_hrdata[`MCD_ST_PEND_BIT] = state_ff;
      nxt_hrdata[`MCD_ST_UNDEF_BIT] = last_undef_ff;
      nxt_hrdata[`MCD_ST_RSVD_BIT] = last_rsvd_ff;
      nxt_hrdata[`MCD_ST_IGN_BIT] = resp_ignore_ff;
    end
  end

  // Bus slave: zero wait states, read data registered for the data phase
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
      ctrl_ff <= `MCD_CTRL_RST;
      ill_tx_ff <= `MCD_ILL_RST;
      ill_rx_ff <= `MCD_ILL_RST;
    end
    else
    begin
      wr_pend_ff <= bus_acc & hwrite_in;
      wr_addr_ff <= a_off;
      if (bus_acc && !hwrite_in)
      begin
        hrdata_ff <= nxt_hrdata;
      end
      if (wr_pend_ff && !w_is_data)
      begin
        if (wr_addr_ff == `MCD_OFF_CTRL)
        begin
          ctrl_ff <= hwdata_in[1:0];
        end
        else if (wr_addr_ff == `MCD_OFF_ILL_TX)
        begin
          ill_tx_ff <= hwdata_in;
        end
        else if (wr_addr_ff == `MCD_OFF_ILL_RX)
        begin
          ill_rx_ff <= hwdata_in;
        end
      end
    end
  end

  // Mode data words held in the descriptor entries
  integer i;
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      for (i = 0; i < NUM_WORDS; i = i + 1)
        mdata_ff[i] <= `MCD_DATA_RST;
    end
    // simplified storage keeps the word here
    // only a cleanly completed message writes
    else if (hw_store)
    begin
      mdata_ff[pend_idx_ff] <= rx_word_in;
    end
    // A host write colliding with a completion store is dropped
    else if (wr_pend_ff && w_is_data)
    begin
      mdata_ff[w_idx] <= hwdata_in[DATA_W-1:0];
    end
  end

  // Command response decision and receive word tracking
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_ff <= ST_IDLE;
      resp_valid_ff <= 1'b0;
      resp_ignore_ff <= 1'b0;
      resp_status_ff <= 1'b0;
      resp_tx_data_ff <= 1'b0;
      resp_rx_data_ff <= 1'b0;
      func_ff <= `MCD_FN_OTHER;
      tx_word_ff <= `MCD_DATA_RST;
      tx_from_buf_ff <= 1'b0;
      merr_ff <= 1'b0;
      last_code_ff <= 5'h00;
      last_tr_ff <= 1'b0;
      last_bcast_ff <= 1'b0;
      last_undef_ff <= 1'b0;
      last_rsvd_ff <= 1'b0;
      pend_idx_ff <= 5'h00;
      store_we_ff <= 1'b0;
      store_sel_ff <= 6'h00;
      store_data_ff <= `MCD_DATA_RST;
    end
    else
    begin
      resp_valid_ff <= cmd_valid_in;
      store_we_ff <= 1'b0;
      case (state_ff)
        ST_IDLE: state_ff <= ST_IDLE;
        ST_WAIT:
        begin
          if (msg_done_in)
          begin
            state_ff <= ST_IDLE;
            // normal storage goes to the assigned buffer
            // no circular mode: one fixed slot per command
            if (!msg_err_in && !sms)
            begin
              store_we_ff <= 1'b1;
              store_sel_ff <= {1'b0, 1'b1, pend_idx_ff[3:0]};
              store_data_ff <= rx_word_in;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      if (cmd_valid_in)
      begin
        // A new command abandons any unfinished receive
        state_ff <= rx_expect ? ST_WAIT : ST_IDLE;
        pend_idx_ff <= cmd_idx;
        resp_ignore_ff <= cmd_ign;
        resp_status_ff <= ~cmd_ign & ~cmd_bcast_in;
        // legal undefined codes move data too
        resp_tx_data_ff <= cmd_ok & cls_has_data & cmd_tr_in & ~cmd_bcast_in;
        resp_rx_data_ff <= rx_expect;
        tx_word_ff <= sms ? mdata_ff[cmd_idx] : `MCD_DATA_RST;
        tx_from_buf_ff <= cmd_ok & cls_has_data & cmd_tr_in & ~sms;
        if (!cmd_ign)
        begin
          merr_ff <= cmd_illegal;
          func_ff <= cls_func;
          last_code_ff <= cmd_code_in;
          last_tr_ff <= cmd_tr_in;
          last_bcast_ff <= cmd_bcast_in;
          last_undef_ff <= cls_undef;
          last_rsvd_ff <= cls_rsvd;
        end
      end
    end
  end

  assign hrdata_out = hrdata_ff;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign resp_valid_out = resp_valid_ff;
  assign resp_ignore_out = resp_ignore_ff;
  assign resp_status_out = resp_status_ff;
  assign resp_tx_data_out = resp_tx_data_ff;
  assign resp_rx_data_out = resp_rx_data_ff;
  assign resp_func_out = func_ff;
  assign tx_word_out = tx_word_ff;
  assign tx_from_buf_out = tx_from_buf_ff;
  assign message_error_flag_out = merr_ff;
  assign bus_ctrl_accept_out = 1'b0;
  assign store_we_out = store_we_ff;
  assign store_sel_out = store_sel_ff;
  assign store_data_out = store_data_ff;

endmodule // mcd_mode_decoder

// [tb/mcd_mode_decoder_asserts.sv]
// Checker for the mode code decoder, bound to its top module.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
module mcd_mode_decoder_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Command and completion
  input wire logic cmd_valid_in,
  input wire logic [4:0] cmd_code_in,
  input wire logic cmd_tr_in,
  input wire logic cmd_bcast_in,
  input wire logic msg_done_in,
  input wire logic msg_err_in,
  // Response decision
  input wire logic resp_valid_out,
  input wire logic resp_ignore_out,
  input wire logic resp_status_out,
  input wire logic resp_tx_data_out,
  input wire logic resp_rx_data_out,
  input wire logic [3:0] resp_func_out,
  input wire logic message_error_flag_out,
  input wire logic bus_ctrl_accept_out,
  // Storage
  input wire logic store_we_out,
  input wire logic [5:0] store_sel_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  property p_lat;
    cmd_valid_in |=> resp_valid_out;
  endproperty
  a_lat: assert property (p_lat) else $error("no reply one cycle on");
  property p_nodata;
    cmd_valid_in && !cmd_code_in[4] |=> !resp_tx_data_out && !resp_rx_data_out;
  endproperty
  a_nodata: assert property (p_nodata) else $error("data word on short code");
  property p_txdir;
    resp_valid_out && resp_tx_data_out |-> $past(cmd_tr_in) && !$past(cmd_bcast_in)
      && resp_status_out;
  endproperty
  a_txdir: assert property (p_txdir) else $error("bad transmit decision");
  property p_bcast;
    cmd_valid_in && cmd_bcast_in |=> !resp_status_out;
  endproperty
  a_bcast: assert property (p_bcast) else $error("status on broadcast");
  property p_merr;
    resp_valid_out && message_error_flag_out |-> !resp_tx_data_out && !resp_rx_data_out;
  endproperty
  a_merr: assert property (p_merr) else $error("data word with error");
  property p_ign;
    resp_valid_out && resp_ignore_out |-> !resp_status_out && $stable(message_error_flag_out);
  endproperty
  a_ign: assert property (p_ign) else $error("ignored command answered");
  property p_func;
    cmd_valid_in && cmd_tr_in && cmd_code_in < 5'h09 |=>
      resp_func_out == $past(cmd_code_in[3:0]);
  endproperty
  a_func: assert property (p_func) else $error("bad function decode");
  property p_store;
    store_we_out |-> $past(msg_done_in) && !$past(msg_err_in) && store_sel_out[5:4] == 2'h1;
  endproperty
  a_store: assert property (p_store) else $error("bad store");
  property p_bc;
    !bus_ctrl_accept_out;
  endproperty
  a_bc: assert property (p_bc) else $error("bus control accepted");
endmodule // mcd_mode_decoder_asserts

bind mcd_mode_decoder mcd_mode_decoder_asserts u_chk (.clk_in, .rst_in, .cmd_valid_in,
  .cmd_code_in, .cmd_tr_in, .cmd_bcast_in, .msg_done_in, .msg_err_in, .resp_valid_out,
  .resp_ignore_out, .resp_status_out, .resp_tx_data_out, .resp_rx_data_out, .resp_func_out,
  .message_error_flag_out, .bus_ctrl_accept_out, .store_we_out, .store_sel_out);

// [tb/mcd_bus_ctrl_model.sv]
// Bus controller model: issues mode commands and ends messages.
// Assumes its tasks are called from one process.
`timescale 1ns/1ps
module mcd_bus_ctrl_model (
  // Clock
  input wire logic clk_in,
  // Command and message end
  output logic cmd_valid_out = 1'b0,
  output logic [4:0] cmd_code_out = 5'h00,
  output logic cmd_tr_out = 1'b0,
  output logic cmd_bcast_out = 1'b0,
  output logic msg_done_out = 1'b0,
  output logic msg_err_out = 1'b0,
  output logic [15:0] rx_word_out = 16'h0000
);
  task automatic send(input logic [4:0] c, input logic t, input logic b);
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_code_out <= c;
    cmd_tr_out <= t;
    cmd_bcast_out <= b;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_code_out <= ~c;
  endtask

  task automatic finish(input int gap, input logic e, input logic [15:0] w);
    repeat (gap) @(posedge clk_in);
    msg_done_out <= 1'b1;
    msg_err_out <= e;
    rx_word_out <= w;
    @(posedge clk_in);
    msg_done_out <= 1'b0;
    msg_err_out <= ~e;
    // Released word lines show junk, not the last value
    rx_word_out <= ~w;
  endtask
endmodule // mcd_bus_ctrl_model

// [tb/tb_mode_code_command_decoder.sv]
// Testbench for the mode code decoder: AHB-Lite master tasks, a bus
// controller model and a queued result checker.
// Assumes the decoder answers each command one cycle later.
`timescale 1ns/1ps
module tb_mode_code_command_decoder;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h0;
  logic [31:0] hwdata_in = 32'h0;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out, cmd_valid_in, cmd_tr_in, cmd_bcast_in, msg_done_in, msg_err_in;
  wire [4:0] cmd_code_in;
  wire [15:0] rx_word_in, tx_word_out, store_data_out;
  wire resp_valid_out, resp_ignore_out, resp_status_out, resp_tx_data_out, resp_rx_data_out;
  wire tx_from_buf_out, message_error_flag_out, bus_ctrl_accept_out, store_we_out;
  wire [3:0] resp_func_out;
  wire [5:0] store_sel_out;
  logic [25:0] q[$];
  logic [21:0] sq[$];
  logic [25:0] ev;
  logic [21:0] sv;
  logic [15:0] mem [32] = '{default: 16'h0};
  logic [63:0] ill = 64'h0;
  logic [31:0] seed = 32'h5E;
  logic [31:0] r;
  logic uci = 1'b0, sms = 1'b0, merr = 1'b0;
  logic [3:0] lf = 4'hF;
  int n_fail = 0, samples_checked = 0;

  mcd_mode_decoder uut (.clk_in, .rst_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
    .hsize_in, .hwdata_in, .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out,
    .hresp_out, .cmd_valid_in, .cmd_code_in, .cmd_tr_in, .cmd_bcast_in, .msg_done_in,
    .msg_err_in, .rx_word_in, .resp_valid_out, .resp_ignore_out, .resp_status_out,
    .resp_tx_data_out, .resp_rx_data_out, .resp_func_out, .tx_word_out, .tx_from_buf_out,
    .message_error_flag_out, .bus_ctrl_accept_out, .store_we_out, .store_sel_out,
    .store_data_out);
  mcd_bus_ctrl_model u_bc (.clk_in, .cmd_valid_out(cmd_valid_in), .cmd_code_out(cmd_code_in),
    .cmd_tr_out(cmd_tr_in), .cmd_bcast_out(cmd_bcast_in), .msg_done_out(msg_done_in),
    .msg_err_out(msg_err_in), .rx_word_out(rx_word_in));

  always #25 clk_in = ~clk_in;

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", n, x, s);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d fails %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
    output logic [31:0] v);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= w;
    hsize_in <= 3'h2;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    v = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(a, 1'b1, d, v);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    bus(a, 1'b0, 32'h0, v);
    chk("register", v, x);
  endtask

  task automatic issue(input logic [4:0] c, input logic t, input logic b, input logic e);
    logic u, ok, il, tx, rx;
    logic [3:0] f;
    logic [15:0] w;
    u = t ? (c == 17 || c == 20 || c == 21) : (c < 17 || c == 18 || c == 19);
    ok = t ? (c == 1 || (c > 2 && c < 16)) : (c == 17 || c > 19);
    il = ill[{t, c}] || (b && !ok);
    f = 4'hF;
    case ({t, c})
      6'h30: f = 4'h9;
      6'h32: f = 4'hB;
      6'h33: f = 4'hC;
      6'h11: f = 4'hA;
      6'h14: f = 4'hD;
      6'h15: f = 4'hE;
      default: if (t && c < 9) f = c[3:0];
    endcase
    tx = 1'b0;
    rx = 1'b0;
    w = 16'(xs());
    if (u && uci)
      // Ignored command keeps the last function in status
      q.push_back({16'h0, 2'h1, 3'h0, merr, lf});
    else
    begin
      merr = il;
      lf = f;
      tx = !il && c[4] && t && !b;
      rx = !il && c[4] && !t;
      q.push_back({((tx && sms) ? mem[{t, c[3:0]}] : 16'h0), tx && !sms, 1'b0, !b, tx, rx,
        il, f});
    end
    // keep word only on clean end
    if (rx && !e && sms)
      mem[c[3:0]] = w;
    else if (rx && !e)
      sq.push_back({2'h1, c[3:0], w});
    u_bc.send(c, t, b);
    u_bc.finish(int'(xs() % 4), e, w);
  endtask

  always @(negedge clk_in)
  begin
    if (resp_valid_out === 1'b1)
    begin
      ev = q.size() ? q.pop_front() : 'x;
      chk("reply", {tx_word_out, tx_from_buf_out, resp_ignore_out, resp_status_out,
        resp_tx_data_out, resp_rx_data_out, message_error_flag_out,
        resp_func_out}, ev);
    end
    if (store_we_out === 1'b1)
    begin
      sv = sq.size() ? sq.pop_front() : 'x;
      chk("store", {store_sel_out, store_data_out}, sv);
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(8'h00, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 64; i++) issue(i[4:0], i[5], 1'b0, 1'b0);
    uci = 1'b1;
    ill = {xs(), xs()};
    wr(8'h00, {30'h0, sms, uci});
    wr(8'h04, ill[63:32]);
    wr(8'h08, ill[31:0]);
    rd(8'h04, ill[63:32]);
    rd(8'h08, ill[31:0]);
    for (int i = 0; i < 64; i++)
    begin
      r = xs();
      issue(i[4:0], i[5], r[0], r[1]);
    end
    // Simplified storage: host loads transmit words first
    sms = 1'b1;
    uci = 1'b0;
    ill = 64'h0;
    wr(8'h00, {30'h0, sms, uci});
    wr(8'h04, 32'h0);
    wr(8'h08, 32'h0);
    for (int i = 0; i < 16; i++)
    begin
      mem[16 + i] = 16'(xs());
      wr(8'(32'hC0 + 4 * i), {16'h0, mem[16 + i]});
    end
    for (int i = 0; i < 32; i++)
      if (!i[4] || i[3:1] != 3'h1) issue(i[4:0] | 5'h10, i[4], 1'b0, i[1]);
    for (int i = 0; i < 16; i++) rd(8'(32'h80 + 4 * i), {16'h0, mem[i]});
    // Last command was reserved code 31, transmit, no receive pending
    rd(8'h0C, 32'h000047BF);
    repeat (3) @(posedge clk_in);
    chk("pending", 32'(q.size() + sq.size()), 32'h0);
    end_of_test();
  end

  initial
  begin
    #400000;
    n_fail++;
    end_of_test();
  end
endmodule // tb_mode_code_command_decoder
